// ---- dv/kbi_asserts.sv ----
// Checker on the keyboard level interrupt top ports.
`timescale 1ns/1ns
`default_nettype none
module kbi_asserts
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire kbi_pkg::kbi_sfr_req_t sfr_req,
	input wire kbi_pkg::kbi_sfr_rsp_t sfr_rsp,
	input wire logic [7:0] key_pins,
	input wire logic keypad_global_irq_enable,
	input wire logic [7:0] key_pins_sync,
	input wire logic [7:0] key_line_irq_mask,
	input wire logic keypad_irq_request,
	input wire logic keypad_wake
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	sequence s_keep;
		keypad_wake && !sfr_req.wr;
	endsequence
	AST_GATE: assert property (keypad_irq_request ==
		(keypad_wake && keypad_global_irq_enable)) else $error("gate");
	AST_MASK: assert property (key_line_irq_mask == 8'h00 |->
		!keypad_wake) else $error("mask");
	AST_STICKY: assert property (s_keep |=> keypad_wake)
		else $error("sticky");
	AST_RST: assert property ($rose(arst_n) |-> !keypad_wake &&
		key_line_irq_mask == 8'h00) else $error("reset");
	AST_ENWR: assert property (sfr_req.wr && sfr_req.addr == 8'h9D |=>
		key_line_irq_mask == $past(sfr_req.wdata)) else $error("en");
	AST_RDEN: assert property (sfr_req.rd && sfr_req.addr == 8'h9D |->
		sfr_rsp.rdata == key_line_irq_mask) else $error("rden");
	AST_UNMAP: assert property (sfr_req.rd && sfr_req.addr > 8'h9E |->
		!sfr_rsp.hit && sfr_rsp.rdata == 8'h00) else $error("unmap");
	AST_SYNC: assert property ($past(arst_n, 2) && $past(arst_n) |->
		key_pins_sync == $past(key_pins, 2)) else $error("sync");
endmodule
bind kbi_top kbi_asserts u_chk(.*);
`default_nettype wire

// ---- dv/kbi_keys.sv ----
// Keyboard switch model: a pressed key pulls its line low.
`timescale 1ns/1ns
`default_nettype none
module kbi_keys
(
	input wire logic [7:0] press,
	output logic [7:0] key_pins
);
	// Lines have pull-ups, so a released key reads high.
	assign key_pins = ~press;
endmodule
`default_nettype wire

// ---- dv/key_matrix_level_interrupt_tb.sv ----
// Testbench for the keyboard level interrupt.
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin \
	num_errors++; $display("[FAIL] %s exp %h got %h", n, e, a); end end
module key_matrix_level_interrupt_tb;
	logic core_clk, arst_n, glob, irq, wake;
	logic [7:0] press, pins, ef;
	logic [7:0] rows[4][4] = '{'{8'h00, 8'hFF, 8'h01, 8'h01},
		'{8'hFF, 8'h0F, 8'h01, 8'h01}, '{8'hFF, 8'h01, 8'h01, 8'h01},
		'{8'h00, 8'hFF, 8'h80, 8'h00}};
	kbi_pkg::kbi_sfr_req_t req;
	kbi_pkg::kbi_sfr_rsp_t rsp;
	int num_errors, n_tests, cyc;
	kbi_keys u_keys(.press(press), .key_pins(pins));
	kbi_top DUT(.core_clk(core_clk), .arst_n(arst_n), .sfr_req(req),
		.sfr_rsp(rsp), .key_pins(pins), .keypad_global_irq_enable(glob),
		.key_pins_sync(), .key_line_irq_mask(), .keypad_irq_request(irq),
		.keypad_wake(wake));
	task finish_test();
		$display("errors %0d checks %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task wr(input logic [7:0] a, d);
		@(posedge core_clk);
		req <= '{1'b1, 1'b0, a, d};
		@(posedge core_clk);
		req <= '0;
	endtask
	task rd(input logic [7:0] a, e);
		@(posedge core_clk);
		req <= '{1'b0, 1'b1, a, 8'h00};
		#1;
		`CHK("rdata", e, rsp.rdata)
		@(posedge core_clk);
		req <= '0;
	endtask
	initial
	begin
		core_clk = 0;
		forever #5 core_clk = ~core_clk;
	end
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			num_errors++;
			finish_test();
		end
	end
	initial
	begin
		arst_n = 0;
		req = '0;
		press = 0;
		glob = 0;
		repeat (10) @(posedge core_clk);
		arst_n <= 1;
		rd(8'h9C, 8'h00);
		rd(8'h9D, 8'h00);
		rd(8'h9E, 8'h00);
		for (int i = 0; i < 4; i++)
		begin
			wr(8'h9C, rows[i][0]);
			wr(8'h9D, rows[i][1]);
			press <= rows[i][2];
			glob <= rows[i][3][0];
			repeat (4) @(posedge core_clk);
			wr(8'h9E, 8'h00);
			ef = rows[i][0] ~^ ~rows[i][2];
			rd(8'h9E, ef);
			`CHK("irq", |(ef & rows[i][1]) & rows[i][3][0], irq)
			`CHK("wake", |(ef & rows[i][1]), wake)
		end
		press <= 8'h00;
		repeat (4) @(posedge core_clk);
		rd(8'h9E, 8'h80);
		wr(8'h9E, 8'h00);
		rd(8'h9E, 8'h00);
		rd(8'h9F, 8'h00);
		wr(8'h9D, 8'hFF);
		arst_n <= 0;
		repeat (2) @(posedge core_clk);
		arst_n <= 1;
		rd(8'h9D, 8'h00);
		rd(8'h9E, 8'h00);
		finish_test();
	end
endmodule
`default_nettype wire

// ---- src/kbi_line.sv ----
// One keyboard line: pin synchroniser, level match and sticky flag.
`timescale 1ns/1ns
`default_nettype none

module kbi_line
(
	input  wire logic core_clk,
	input  wire logic arst_n,
	input  wire logic pin_in,
	input  wire logic level_high,
	input  wire logic flag_wr,
	input  wire logic flag_wdata,
	output logic      flag_r,
	output logic      pin_sync
);

	logic [1:0] sync_r;

	// ==========================================================
	// Synchroniser
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			sync_r <= kbi_pkg::KBI_SYNC_RST;
		else
			sync_r <= {sync_r[0], pin_in};
	end

	assign pin_sync = sync_r[1];

	// ==========================================================
	// Sticky flag
	// A detection in the cycle of a software write wins, so that a
	// key still held during the clear is never lost.
	logic match;
	assign match = (pin_sync == level_high); // R5

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			flag_r <= 1'h0; // R6
		else if (match)
			flag_r <= 1'h1; // R1
		else if (flag_wr)
			flag_r <= flag_wdata; // R3
	end

endmodule

`default_nettype wire

// ---- src/kbi_pkg.sv ----
// Package of constants and carrier types for the keyboard level interrupt.
// What this block does
// R1: Set line flag when pin shows selected level.
// R2: Flag requests only while line enable set.
// R3: Flags sticky until software writes zero.
// R4: Enable zero leaves pin ordinary I/O.
// R5: Level select zero low, one high.
// R6: All three registers reset to zero.
// R7: Eight line requests share one vector.
// R8: Global enable gates combined keyboard request.
// R9: Detection and wake work in idle, power-down. Here detection needs core_clk running.
// R10: Request is OR of flag AND enable.
package kbi_pkg;

	// ==========================================================
	// Register map
	localparam logic [7:0] KBI_OFS_LEVEL_SEL = 8'h9C;
	localparam logic [7:0] KBI_OFS_LINE_EN   = 8'h9D;
	localparam logic [7:0] KBI_OFS_FLAGS     = 8'h9E;
	localparam logic [7:0] KBI_RST_LEVEL_SEL = 8'h00;
	localparam logic [7:0] KBI_RST_LINE_EN   = 8'h00;
	localparam logic [7:0] KBI_RST_FLAGS     = 8'h00;
	localparam int         KBI_LINES         = 8;
	// The synchroniser starts at the idle pin level, high under the
	// pull-ups, so low-level detection cannot fire falsely after reset.
	localparam logic [1:0] KBI_SYNC_RST      = 2'h3;

	// ==========================================================
	// Carrier types
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} kbi_sfr_req_t;

	typedef struct packed {
		logic       hit;
		logic [7:0] rdata;
	} kbi_sfr_rsp_t;

endpackage

// ---- src/kbi_top.sv ----
// Keyboard level interrupt: special function registers and eight lines.
`timescale 1ns/1ns
`default_nettype none

module kbi_top
(
	input  wire logic                  core_clk,
	input  wire logic                  arst_n,
	input  wire kbi_pkg::kbi_sfr_req_t sfr_req,
	output kbi_pkg::kbi_sfr_rsp_t      sfr_rsp,
	input  wire logic [7:0]            key_pins,
	input  wire logic                  keypad_global_irq_enable,
	output logic [7:0]                 key_pins_sync,
	output logic [7:0]                 key_line_irq_mask,
	output logic                       keypad_irq_request,
	output logic                       keypad_wake
);

	logic [7:0] key_level_select_r;
	logic [7:0] key_line_enable_r;
	logic [7:0] key_line_flags;
	logic       wr_sel;
	logic       wr_en;
	logic       wr_flags;
	logic       line_req;

	assign wr_sel   = sfr_req.wr
		&& (sfr_req.addr == kbi_pkg::KBI_OFS_LEVEL_SEL);
	assign wr_en    = sfr_req.wr
		&& (sfr_req.addr == kbi_pkg::KBI_OFS_LINE_EN);
	assign wr_flags = sfr_req.wr
		&& (sfr_req.addr == kbi_pkg::KBI_OFS_FLAGS);

	// ==========================================================
	// Control registers
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			key_level_select_r <= kbi_pkg::KBI_RST_LEVEL_SEL; // R6
		else if (wr_sel)
			key_level_select_r <= sfr_req.wdata;
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			key_line_enable_r <= kbi_pkg::KBI_RST_LINE_EN; // R6
		else if (wr_en)
			key_line_enable_r <= sfr_req.wdata;
	end

	// ==========================================================
	// Lines
	genvar i;
	generate
		for (i = 0; i < kbi_pkg::KBI_LINES; i++)
		begin : g_line
			kbi_line u_line
			(
				.core_clk   (core_clk),
				.arst_n     (arst_n),
				.pin_in     (key_pins[i]),
				.level_high (key_level_select_r[i]),
				.flag_wr    (wr_flags),
				.flag_wdata (sfr_req.wdata[i]),
				.flag_r     (key_line_flags[i]),
				.pin_sync   (key_pins_sync[i])
			);
		end
	endgenerate

	// ==========================================================
	// Request
	// Masked lines keep flagging; only the request is gated, so that
	// software may poll them as plain inputs.
	assign key_line_irq_mask = key_line_enable_r; // R4
	assign line_req = |(key_line_flags & key_line_enable_r); // R2 R10 R7
	assign keypad_irq_request = line_req && keypad_global_irq_enable; // R8
	// No clock gating here: the wake term is combinational, but new keys are only
	// flagged while core_clk runs, so a press with the clock stopped is not seen.
	assign keypad_wake = line_req; // R9

	// ==========================================================
	// Read path
	always_comb
	begin
		sfr_rsp = '0;
		if (sfr_req.rd)
		begin
			unique case (sfr_req.addr)
				kbi_pkg::KBI_OFS_LEVEL_SEL:
				begin
					sfr_rsp.hit   = 1'h1;
					sfr_rsp.rdata = key_level_select_r;
				end
				kbi_pkg::KBI_OFS_LINE_EN:
				begin
					sfr_rsp.hit   = 1'h1;
					sfr_rsp.rdata = key_line_enable_r;
				end
				kbi_pkg::KBI_OFS_FLAGS:
				begin
					sfr_rsp.hit   = 1'h1;
					sfr_rsp.rdata = key_line_flags;
				end
				default:
				begin
					sfr_rsp.hit   = 1'h0;
					sfr_rsp.rdata = 8'h00;
				end
			endcase
		end
	end

endmodule

`default_nettype wire
